/* File: bmc_pkg.sv */
// shared constants, types and menu shape for the button menu controller
package bmc_pkg;

  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned TICK_MS      = 100;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DEBOUNCE_MS  = 20;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;

  localparam int unsigned ENTER_HOLD_MS = 2000;
  localparam int unsigned ABORT_HOLD_MS = 4000;
  localparam int unsigned ESC_HOLD_MS   = 1000;
  localparam int unsigned IDLE_MS       = 300_000;
  localparam int unsigned ESC_SHOW_MS   = 2000;
  localparam int unsigned BLINK_MS      = 500;
  localparam int unsigned FAST_BLINK_MS = 100;

  localparam logic [11:0] ENTER_TICKS = 12'((ENTER_HOLD_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [11:0] ABORT_TICKS = 12'(ABORT_HOLD_MS / TICK_MS);
  localparam logic [11:0] ESC_TICKS   = 12'(ESC_HOLD_MS / TICK_MS);
  localparam logic [11:0] IDLE_TICKS  = 12'(IDLE_MS / TICK_MS);
  localparam logic [4:0]  ESC_SHOW_TICKS = 5'(ESC_SHOW_MS / TICK_MS);
  localparam logic [3:0]  BLINK_TICKS = 4'(BLINK_MS / TICK_MS);
  localparam logic [3:0]  FAST_TICKS  = 4'(FAST_BLINK_MS / TICK_MS);

  localparam logic [2:0] MAIN_LAST = 3'h4;
  localparam logic [2:0] BASE_LAST = 3'h3;
  localparam logic [2:0] DISP_LAST = 3'h4;
  localparam logic [2:0] SWP_LAST  = 3'h4;
  localparam logic [2:0] SYS_LAST  = 3'h5;
  localparam logic [2:0] ITEM_FIRST = 3'h0;

  typedef enum logic [2:0] {
    ST_DISPLAY = 3'b000,
    ST_ARMING  = 3'b001,
    ST_ENTERED = 3'b010,
    ST_MENU    = 3'b011,
    ST_BACK    = 3'b100
  } bmc_state_e;

  typedef enum logic [2:0] {
    SHOW_VALUE = 3'b000,
    SHOW_UNIT  = 3'b001,
    SHOW_MENU  = 3'b010,
    SHOW_RET   = 3'b011,
    SHOW_ESC   = 3'b100
  } bmc_show_e;

  typedef struct packed {
    logic down;
    logic up;
    logic center;
  } bmc_btn_s;

  typedef struct packed {
    logic       sub;
    logic [2:0] main_item;
    logic [2:0] sub_item;
  } bmc_menu_pos_s;

  localparam bmc_menu_pos_s MENU_START = '{sub: 1'b0, main_item: 3'h0, sub_item: 3'h0};

  // last index of the menu in which the cursor stands
  function automatic logic [2:0] bmc_last_item(input logic sub, input logic [2:0] main_item);
    logic [2:0] last;
    last = MAIN_LAST;
    if (sub) begin
      case (main_item)
        3'h0:    last = BASE_LAST;
        3'h1:    last = DISP_LAST;
        3'h2:    last = SWP_LAST;
        3'h3:    last = SYS_LAST;
        default: last = MAIN_LAST;
      endcase
    end
    return last;
  endfunction : bmc_last_item

endpackage : bmc_pkg

/* File: bmc_button_menu_controller.sv */
// operator button, led feedback and menu navigation controller
// Functional notes
// - touched buttons flash leds: down left, up right, both both, center both fast
// - idle leds mirror the switch outputs; feedback never touches the outputs
// - after reset show value, alone or alternating with unit by periods
// - in display mode the value blinks when it is over range
// - in display mode the unit is shown while center is held
// - a single arrow does nothing in display mode
// - both arrows held at least 2 s enter config at first main item
// - both arrows still held at 4 s abandon entry back to display
// - every config session starts at the first main menu item
// - arrows move within the menu, center selects or descends
// - center on a value-only item goes back to the parent item
// - return item goes to parent; in main menu back to display
// - navigation wraps at both ends of each menu
// - both arrows in a submenu go to parent menu with blinking return indication; in main menu straight back to display
// - both arrows held over 1 s in a submenu leave to display with blinking escape
// - 5 minutes without touch in config returns to display mode
`timescale 1ns/100ps
`default_nettype none

module bmc_button_menu_controller
  import bmc_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned DEB_CYC  = DEBOUNCE_CYC
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst,
  input  wire logic          i_btn_down_raw,
  input  wire logic          i_btn_up_raw,
  input  wire logic          i_btn_center_raw,
  input  wire logic          i_first_switch_point,
  input  wire logic          i_second_switch_point,
  input  wire logic          i_overrange,
  input  wire logic [9:0]    i_value_period,
  input  wire logic [9:0]    i_unit_period,
  input  wire logic          i_item_is_value,
  output var  logic          o_led_left,
  output var  logic          o_led_right,
  output var  logic          o_config_mode,
  output var  bmc_show_e     o_show_sel,
  output var  logic          o_show_blank,
  output var  bmc_menu_pos_s o_menu_pos,
  output var  logic          o_item_select
);

  logic [2:0]    raw;
  logic [2:0]    sync1_reg;
  logic [2:0]    sync2_reg;
  logic [2:0]    deb_reg;
  bmc_btn_s      btn;
  bmc_btn_s      btn_q_reg;
  logic          both;
  logic          both_q_reg;
  logic          both_rise;
  logic          any_btn;
  logic          down_rise;
  logic          up_rise;
  logic          center_rise;

  logic [23:0]   tick_cnt_reg;
  logic          tick_reg;
  logic [3:0]    slow_cnt_reg;
  logic [3:0]    fast_cnt_reg;
  logic          slow_ph_reg;
  logic          fast_ph_reg;

  bmc_state_e    state_reg;
  bmc_menu_pos_s pos_reg;
  logic [11:0]   hold_reg;
  logic [11:0]   idle_reg;
  logic [4:0]    esc_reg;
  logic          go_esc;
  logic [9:0]    phase_cnt_reg;
  logic          phase_unit_reg;
  logic [2:0]    last_item;
  logic [9:0]    cur_period;

  assign raw = {i_btn_down_raw, i_btn_up_raw, i_btn_center_raw};

  // two-stage synchroniser then stable-count debounce per button
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_btn
      logic [23:0] deb_cnt_reg;
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          sync1_reg[g]  <= 1'b0;
          sync2_reg[g]  <= 1'b0;
        end else begin
          sync1_reg[g]  <= raw[g];
          sync2_reg[g]  <= sync1_reg[g];
        end
      end
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          deb_cnt_reg <= 24'h000000;
          deb_reg[g]  <= 1'b0;
        end else if (sync2_reg[g] == deb_reg[g]) begin
          deb_cnt_reg <= 24'h000000;
        end else if (deb_cnt_reg >= 24'(DEB_CYC - 1)) begin
          deb_cnt_reg <= 24'h000000;
          deb_reg[g]  <= sync2_reg[g];
        end else begin
          deb_cnt_reg <= deb_cnt_reg + 24'h000001;
        end
      end
    end
  endgenerate

  assign btn         = bmc_btn_s'(deb_reg);
  assign both        = btn.down & btn.up;
  assign both_rise   = both & ~both_q_reg;
  assign any_btn     = btn.down | btn.up | btn.center;
  assign down_rise   = btn.down & ~btn_q_reg.down & ~btn.up;
  assign up_rise     = btn.up & ~btn_q_reg.up & ~btn.down;
  assign center_rise = btn.center & ~btn_q_reg.center & ~btn.down & ~btn.up;
  assign last_item   = bmc_last_item(pos_reg.sub, pos_reg.main_item);
  assign go_esc      = (state_reg == ST_BACK) && both && (hold_reg > ESC_TICKS);
  assign cur_period  = phase_unit_reg ? i_unit_period : i_value_period;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      btn_q_reg  <= '0;
      both_q_reg <= 1'b0;
    end else begin
      btn_q_reg  <= btn;
      both_q_reg <= both;
    end
  end

  // common prescaler and blink phases
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tick_cnt_reg <= 24'h000000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg >= 24'(TICK_CYC - 1)) begin
      tick_cnt_reg <= 24'h000000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 24'h000001;
      tick_reg     <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      slow_cnt_reg <= 4'h0;
      fast_cnt_reg <= 4'h0;
      slow_ph_reg  <= 1'b0;
      fast_ph_reg  <= 1'b0;
    end else if (tick_reg) begin
      if (slow_cnt_reg >= BLINK_TICKS - 4'h1) begin
        slow_cnt_reg <= 4'h0;
        slow_ph_reg  <= ~slow_ph_reg;
      end else begin
        slow_cnt_reg <= slow_cnt_reg + 4'h1;
      end
      if (fast_cnt_reg >= FAST_TICKS - 4'h1) begin
        fast_cnt_reg <= 4'h0;
        fast_ph_reg  <= ~fast_ph_reg;
      end else begin
        fast_cnt_reg <= fast_cnt_reg + 4'h1;
      end
    end
  end

  // hold timer restarts on each two-arrow gesture
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hold_reg <= 12'h000;
    end else if (both_rise) begin
      hold_reg <= 12'h000;
    end else if (tick_reg && hold_reg != 12'hFFF) begin
      hold_reg <= hold_reg + 12'h001;
    end
  end

  // inactivity timer, cleared by any touch
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      idle_reg <= 12'h000;
    end else if (any_btn || state_reg == ST_DISPLAY) begin
      idle_reg <= 12'h000;
    end else if (tick_reg && idle_reg != 12'hFFF) begin
      idle_reg <= idle_reg + 12'h001;
    end
  end

  // mode and menu cursor
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg     <= ST_DISPLAY;
      pos_reg       <= MENU_START;
      o_item_select <= 1'b0;
    end else begin
      o_item_select <= 1'b0;
      case (state_reg)
        ST_DISPLAY: begin
          if (both_rise) begin
            state_reg <= ST_ARMING;
          end
        end
        ST_ARMING: begin
          if (!both) begin
            state_reg <= ST_DISPLAY;
          end else if (hold_reg >= ENTER_TICKS) begin
            state_reg <= ST_ENTERED;
            pos_reg   <= MENU_START;
          end
        end
        ST_ENTERED: begin
          if (both && hold_reg >= ABORT_TICKS) begin
            state_reg <= ST_DISPLAY;
          end else if (!btn.down && !btn.up) begin
            state_reg <= ST_MENU;
          end
        end
        ST_MENU: begin
          if (idle_reg >= IDLE_TICKS) begin
            state_reg <= ST_DISPLAY;
          end else if (both_rise) begin
            if (pos_reg.sub) begin
              pos_reg.sub <= 1'b0;
              state_reg   <= ST_BACK;
            end else begin
              state_reg   <= ST_DISPLAY;
            end
          end else if (down_rise) begin
            if (pos_reg.sub) begin
              pos_reg.sub_item <= (pos_reg.sub_item == last_item) ? ITEM_FIRST
                                  : pos_reg.sub_item + 3'h1;
            end else begin
              pos_reg.main_item <= (pos_reg.main_item == last_item) ? ITEM_FIRST
                                   : pos_reg.main_item + 3'h1;
            end
          end else if (up_rise) begin
            if (pos_reg.sub) begin
              pos_reg.sub_item <= (pos_reg.sub_item == ITEM_FIRST) ? last_item
                                  : pos_reg.sub_item - 3'h1;
            end else begin
              pos_reg.main_item <= (pos_reg.main_item == ITEM_FIRST) ? last_item
                                   : pos_reg.main_item - 3'h1;
            end
          end else if (center_rise) begin
            if (!pos_reg.sub) begin
              if (pos_reg.main_item == last_item) begin
                state_reg <= ST_DISPLAY;
              end else begin
                pos_reg.sub      <= 1'b1;
                pos_reg.sub_item <= ITEM_FIRST;
              end
            end else if (pos_reg.sub_item == last_item || i_item_is_value) begin
              pos_reg.sub <= 1'b0;
            end else begin
              o_item_select <= 1'b1;
            end
          end
        end
        ST_BACK: begin
          if (go_esc) begin
            state_reg <= ST_DISPLAY;
          end else if (!btn.down && !btn.up) begin
            state_reg <= ST_MENU;
          end
        end
        default: begin
          state_reg <= ST_DISPLAY;
        end
      endcase
    end
  end

  // escape indication shown for a while after leaving by hold
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      esc_reg <= 5'h00;
    end else if (go_esc) begin
      esc_reg <= ESC_SHOW_TICKS;
    end else if (state_reg != ST_DISPLAY || |(deb_reg & ~btn_q_reg)) begin
      esc_reg <= 5'h00;
    end else if (tick_reg && esc_reg != 5'h00) begin
      esc_reg <= esc_reg - 5'h01;
    end
  end

  // value and unit alternation by configured periods, in ticks
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      phase_cnt_reg  <= 10'h000;
      phase_unit_reg <= 1'b0;
    end else if (i_unit_period == 10'h000) begin
      phase_cnt_reg  <= 10'h000;
      phase_unit_reg <= 1'b0;
    end else if (tick_reg) begin
      if (phase_cnt_reg + 10'h001 >= cur_period) begin
        phase_cnt_reg  <= 10'h000;
        phase_unit_reg <= ~phase_unit_reg;
      end else begin
        phase_cnt_reg  <= phase_cnt_reg + 10'h001;
      end
    end
  end

  // display selection and blanking
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_show_sel   <= SHOW_VALUE;
      o_show_blank <= 1'b0;
    end else begin
      case (state_reg)
        ST_DISPLAY, ST_ARMING: begin
          if (esc_reg != 5'h00) begin
            o_show_sel   <= SHOW_ESC;
            o_show_blank <= slow_ph_reg;
          end else if (btn.center || phase_unit_reg) begin
            o_show_sel   <= SHOW_UNIT;
            o_show_blank <= 1'b0;
          end else begin
            o_show_sel   <= SHOW_VALUE;
            o_show_blank <= i_overrange & slow_ph_reg;
          end
        end
        ST_BACK: begin
          o_show_sel   <= SHOW_RET;
          o_show_blank <= slow_ph_reg;
        end
        default: begin
          o_show_sel   <= SHOW_MENU;
          o_show_blank <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_config_mode <= 1'b0;
      o_menu_pos    <= MENU_START;
    end else begin
      o_config_mode <= (state_reg == ST_ENTERED) || (state_reg == ST_MENU)
                       || (state_reg == ST_BACK);
      o_menu_pos    <= pos_reg;
    end
  end

  // led feedback overrides only the lamps, never the switch outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_led_left  <= 1'b0;
      o_led_right <= 1'b0;
    end else if (btn.center) begin
      o_led_left  <= fast_ph_reg;
      o_led_right <= fast_ph_reg;
    end else if (btn.down || btn.up) begin
      o_led_left  <= btn.down & slow_ph_reg;
      o_led_right <= btn.up & slow_ph_reg;
    end else begin
      o_led_left  <= i_first_switch_point;
      o_led_right <= i_second_switch_point;
    end
  end

endmodule : bmc_button_menu_controller
`default_nettype wire

/* File: bmc_checker_sva.sv */
// port assertions for the button menu controller
`timescale 1ns/100ps
`default_nettype none
module bmc_checker_sva
  import bmc_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned DEB_CYC  = DEBOUNCE_CYC
) (
  input wire logic          i_clk_sys,
  input wire logic          i_rst,
  input wire logic          i_btn_down_raw,
  input wire logic          i_btn_up_raw,
  input wire logic          i_btn_center_raw,
  input wire logic          i_first_switch_point,
  input wire logic          i_overrange,
  input wire logic          o_led_left,
  input wire logic          o_led_right,
  input wire logic          o_config_mode,
  input wire bmc_show_e     o_show_sel,
  input wire logic          o_show_blank,
  input wire bmc_menu_pos_s o_menu_pos,
  input wire logic          o_item_select
);
  int unsigned both_reg;
  int unsigned quiet_reg;
  // cycles with both arrows held
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !(i_btn_down_raw && i_btn_up_raw)) both_reg <= 0;
    else both_reg <= both_reg + 1;
  end
  // cycles with no touch at all
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_btn_down_raw || i_btn_up_raw || i_btn_center_raw) quiet_reg <= 0;
    else quiet_reg <= quiet_reg + 1;
  end
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  sequence s_down_only;
    (i_btn_down_raw && !i_btn_up_raw && !i_btn_center_raw) [*8];
  endsequence
  sequence s_disp_center;
    (i_btn_center_raw && !o_config_mode) [*8];
  endsequence
  sequence s_value_steady;
    (o_show_sel == SHOW_VALUE && !i_overrange) [*3];
  endsequence
  a_entry_hold: assert property (
    $rose(o_config_mode) |-> both_reg >= (ENTER_TICKS - 1) * TICK_CYC)
    else $error("config entered too early");
  a_entry_start: assert property (
    $rose(o_config_mode) |-> o_show_sel == SHOW_MENU && o_menu_pos == MENU_START)
    else $error("config entry not at first item");
  a_long_hold_exit: assert property (
    both_reg == (ABORT_TICKS + 3) * TICK_CYC |-> !o_config_mode)
    else $error("long both hold kept config");
  a_idle_return: assert property (
    quiet_reg == (IDLE_TICKS + 2) * TICK_CYC |-> !o_config_mode)
    else $error("idle config not left");
  a_idle_led_mirror: assert property (
    quiet_reg >= DEB_CYC + 10 |-> o_led_left == $past(i_first_switch_point))
    else $error("idle left led not mirroring");
  a_down_left_only: assert property (
    s_down_only |=> !o_led_right)
    else $error("right led lit on down");
  a_center_unit: assert property (
    s_disp_center |=> o_show_sel == SHOW_UNIT)
    else $error("unit not shown on center");
  a_blank_overrange: assert property (
    s_value_steady |-> !o_show_blank)
    else $error("value blanked in range");
  a_select_pulse: assert property (
    o_item_select |-> o_config_mode && o_menu_pos.sub ##1 !o_item_select)
    else $error("bad select pulse");
endmodule : bmc_checker_sva
bind bmc_button_menu_controller bmc_checker_sva #(.TICK_CYC(TICK_CYC), .DEB_CYC(DEB_CYC)) u_sva (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_btn_down_raw(i_btn_down_raw),
  .i_btn_up_raw(i_btn_up_raw), .i_btn_center_raw(i_btn_center_raw),
  .i_first_switch_point(i_first_switch_point), .i_overrange(i_overrange),
  .o_led_left(o_led_left), .o_led_right(o_led_right), .o_config_mode(o_config_mode),
  .o_show_sel(o_show_sel), .o_show_blank(o_show_blank), .o_menu_pos(o_menu_pos),
  .o_item_select(o_item_select)
);
`default_nettype wire

/* File: bmc_operator.sv */
// operator model: finger levels on the three touch buttons
`timescale 1ns/100ps
`default_nettype none
module bmc_operator
  import bmc_pkg::*;
(
  input  wire logic i_clk_sys,
  output var  logic o_down,
  output var  logic o_up,
  output var  logic o_center
);
  initial begin
    o_down = 1'b0;
    o_up = 1'b0;
    o_center = 1'b0;
  end
  // an untouched pad reads low
  task automatic hold(input bmc_btn_s b);
    @(posedge i_clk_sys);
    o_down <= b.down;
    o_up <= b.up;
    o_center <= b.center;
  endtask : hold
  // a finger stays far longer than the debounce window
  task automatic tap(input bmc_btn_s b);
    hold(b);
    repeat (30) @(posedge i_clk_sys);
    hold(3'h0);
    repeat (30) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask : tap
endmodule : bmc_operator
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the button menu controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import bmc_pkg::*;
  typedef struct packed {
    bmc_btn_s   b;
    logic [1:0] sw;
    bmc_show_e  show;
    logic [4:0] tl;
    logic [4:0] tr;
  } bmc_row_s;
  logic i_clk_sys, i_rst, sw1, sw2, ovr, is_val;
  logic [9:0] vper, uper;
  logic led_l, led_r, cfg, blank, sel_p, b_dn, b_up, b_cn;
  bmc_show_e show;
  bmc_menu_pos_s pos;
  int failures = 0, check_count = 0, cycles = 0, t1, t2, nl, nr, nu, nb, np;
  bmc_row_s rows [4] = '{'{3'h0, 2'h2, SHOW_VALUE, 5'h00, 5'h00},
    '{3'h4, 2'h1, SHOW_VALUE, 5'h04, 5'h00}, '{3'h2, 2'h3, SHOW_VALUE, 5'h00, 5'h04},
    '{3'h1, 2'h0, SHOW_UNIT, 5'h14, 5'h14}};
  always #5 i_clk_sys = ~i_clk_sys;
  bmc_operator op (.i_clk_sys(i_clk_sys), .o_down(b_dn), .o_up(b_up), .o_center(b_cn));
  bmc_button_menu_controller #(.TICK_CYC(10), .DEB_CYC(2)) u_dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_btn_down_raw(b_dn), .i_btn_up_raw(b_up),
    .i_btn_center_raw(b_cn), .i_first_switch_point(sw1), .i_second_switch_point(sw2),
    .i_overrange(ovr), .i_value_period(vper), .i_unit_period(uper), .i_item_is_value(is_val),
    .o_led_left(led_l), .o_led_right(led_r), .o_config_mode(cfg), .o_show_sel(show),
    .o_show_blank(blank), .o_menu_pos(pos), .o_item_select(sel_p));
  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [6:0] e, input logic [6:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic near(input int n, input int e);
    return (e == 0) ? (n == 0) : (n >= e - 1 && n <= e + 1);
  endfunction : near
  task automatic wait_cfg(input logic v, input int lim, output int n);
    n = 0;
    while (cfg !== v && n < lim) begin
      @(negedge i_clk_sys);
      n++;
    end
  endtask : wait_cfg
  task automatic enter(output int n);
    op.hold(3'h6);
    wait_cfg(1'b1, 600, n);
    op.hold(3'h0);
    repeat (30) @(negedge i_clk_sys);
  endtask : enter
  // counts unit samples, blank samples and select pulses
  task automatic watch(input int cyc);
    nu = 0;
    nb = 0;
    np = 0;
    repeat (cyc) begin
      @(negedge i_clk_sys);
      nu += int'(show === SHOW_UNIT);
      nb += int'(blank === 1'b1);
      np += int'(sel_p === 1'b1);
    end
  endtask : watch
  // presses and counts led toggles over 200 cycles, still pressed at return
  task automatic flash(input bmc_btn_s b);
    logic pl, pr;
    nl = 0;
    nr = 0;
    op.hold(b);
    repeat (20) @(negedge i_clk_sys);
    pl = led_l;
    pr = led_r;
    repeat (200) begin
      @(negedge i_clk_sys);
      nl += int'(led_l !== pl);
      nr += int'(led_r !== pr);
      pl = led_l;
      pr = led_r;
    end
  endtask : flash
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    i_clk_sys = 1'b0;
    i_rst <= 1'b1;
    sw1 <= 1'b0;
    sw2 <= 1'b0;
    ovr <= 1'b0;
    is_val <= 1'b0;
    vper <= 10'h00A;
    uper <= 10'h000;
    repeat (3) @(negedge i_clk_sys);
    chk("rst_out", 7'h00, {3'h0, cfg, show});
    chk("rst_pos", 7'h00, pos);
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge i_clk_sys) {sw1, sw2} <= rows[i].sw;
      flash(rows[i].b);
      chk("mode", 7'h00, {6'h00, cfg});
      chk("show", {4'h0, rows[i].show}, {4'h0, show});
      chk("flash_l", 7'h01, {6'h00, near(nl, rows[i].tl)});
      chk("flash_r", 7'h01, {6'h00, near(nr, rows[i].tr)});
      op.hold(3'h0);
      repeat (30) @(negedge i_clk_sys);
      chk("leds", {5'h00, rows[i].sw}, {5'h00, led_l, led_r});
    end
    @(posedge i_clk_sys) vper <= 10'h005;
    uper <= 10'h005;
    watch(200);
    chk("alternate", 7'h01, {6'h00, nu > 40 && nu < 160});
    @(posedge i_clk_sys) uper <= 10'h000;
    @(posedge i_clk_sys) ovr <= 1'b1;
    watch(200);
    chk("over_blink", 7'h01, {6'h00, nb > 60 && nb < 140});
    @(posedge i_clk_sys) ovr <= 1'b0;
    enter(t1);
    chk("enter_time", 7'h01, {6'h00, t1 >= 180 && t1 <= 230});
    chk("enter_show", {4'h0, SHOW_MENU}, {4'h0, show});
    op.tap(3'h2);
    chk("wrap_up", {1'b0, MAIN_LAST, 3'h0}, pos);
    op.tap(3'h4);
    chk("wrap_down", 7'h00, pos);
    op.tap(3'h4);
    op.tap(3'h6);
    chk("both_main", 7'h00, {6'h00, cfg});
    enter(t1);
    chk("restart", 7'h00, pos);
    op.tap(3'h1);
    chk("descend", 7'h40, pos);
    op.tap(3'h2);
    chk("sub_wrap", {1'b1, 3'h0, BASE_LAST}, pos);
    op.tap(3'h1);
    chk("sub_ret", 7'h00, {3'h0, pos[6:3]});
    op.tap(3'h1);
    @(posedge i_clk_sys) is_val <= 1'b1;
    op.tap(3'h1);
    chk("value_item", 7'h00, {3'h0, pos[6:3]});
    @(posedge i_clk_sys) is_val <= 1'b0;
    op.tap(3'h4);
    op.tap(3'h1);
    op.tap(3'h4);
    op.hold(3'h1);
    watch(30);
    op.hold(3'h0);
    repeat (30) @(negedge i_clk_sys);
    chk("select", 7'h01, 7'(np));
    op.hold(3'h6);
    repeat (30) @(negedge i_clk_sys);
    chk("ret_show", {4'h0, SHOW_RET}, {4'h0, show});
    chk("ret_pos", 7'h01, {3'h0, pos[6:3]});
    wait_cfg(1'b0, 200, t1);
    chk("esc_show", {4'h0, SHOW_ESC}, {4'h0, show});
    chk("esc_time", 7'h01, {6'h00, t1 >= 55 && t1 <= 95});
    op.hold(3'h0);
    repeat (30) @(negedge i_clk_sys);
    chk("esc_stays", {4'h0, SHOW_ESC}, {4'h0, show});
    enter(t1);
    op.tap(3'h2);
    op.tap(3'h1);
    chk("ret_main", 7'h00, {6'h00, cfg});
    op.hold(3'h6);
    wait_cfg(1'b1, 600, t1);
    wait_cfg(1'b0, 600, t2);
    op.hold(3'h0);
    repeat (30) @(negedge i_clk_sys);
    chk("abort_time", 7'h01, {6'h00, t1 + t2 >= 385 && t1 + t2 <= 430});
    enter(t1);
    repeat (29000) @(negedge i_clk_sys);
    chk("idle_kept", 7'h01, {6'h00, cfg});
    repeat (2000) @(negedge i_clk_sys);
    chk("idle_exit", 7'h00, {6'h00, cfg});
    enter(t1);
    op.tap(3'h4);
    @(posedge i_clk_sys) i_rst <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk("mid_rst_out", 7'h00, {3'h0, cfg, show});
    chk("mid_rst_pos", 7'h00, pos);
    @(posedge i_clk_sys) i_rst <= 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk("mid_rst_cfg", 7'h00, {6'h00, cfg});
    summarize();
  end
endmodule : testbench
`default_nettype wire
